// [logic/bus_controller.sv]
// Two-wire bus controller that drives the clock and frames transfers.
// Assumes a single target on the bus and a user that waits for o_done.
`timescale 1ns/100ps
module bus_controller #(
	parameter int unsigned QUARTER = twe_pkg::QUARTER_CYC
) (
	// Clock and reset
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst_n,
	// Command
	input  wire logic                       i_go,
	input  wire logic                       i_rd,
	input  wire logic [twe_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [7:0]                 i_count,
	input  wire logic [31:0]                i_wdata,
	// Answer
	output logic                            o_busy,
	output logic                            o_done,
	output logic                            o_nack,
	output logic [twe_pkg::BYTE_W-1:0]      o_rdata,
	output logic                            o_rd_valid,
	// Serial bus
	twe_bus_if.controller                   bus
);
	import twe_pkg::*;

	localparam int unsigned QW = $clog2(QUARTER + 1);

	// ==========================================================
	// Quarter-period enable from a divider
	logic [QW-1:0] qcnt;
	logic          tick;
	assign tick = (qcnt == '0);

	ctl_state_t        state;
	logic [1:0]        q;
	logic [3:0]        bi;
	logic [BYTE_W-1:0] tx_sh;
	logic [BYTE_W-1:0] rx_sh;
	logic [7:0]        left;
	logic [1:0]        widx;
	logic [31:0]       wbuf;
	logic              first;
	logic              rd;
	logic              nacked;
	logic              scl_oe;
	logic              sda_oe;
	logic              rx;
	logic              drv;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qcnt <= '0;
		end else if (state == C_IDLE || tick) begin
			qcnt <= QW'(QUARTER - 1);
		end else begin
			qcnt <= qcnt - 1'b1;
		end
	end

	// Receiving data bytes of a read; ninth slot acks if more wanted
	assign rx  = !first && rd;
	assign drv = rx ? (bi == ACK_SLOT && left != 8'h01)
		: (bi != ACK_SLOT && !tx_sh[BYTE_W-1]); // RL6
	assign o_busy = (state != C_IDLE);

	// ==========================================================
	// Framing engine: q0 set data, q1 raise clock, q2 sample, q3 lower
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state      <= C_IDLE;
			q          <= '0;
			bi         <= '0;
			tx_sh      <= '0;
			rx_sh      <= '0;
			left       <= '0;
			widx       <= '0;
			wbuf       <= '0;
			first      <= 1'b0;
			rd         <= 1'b0;
			nacked     <= 1'b0;
			scl_oe     <= 1'b0;
			sda_oe     <= 1'b0;
			o_done     <= 1'b0;
			o_nack     <= 1'b0;
			o_rdata    <= '0;
			o_rd_valid <= 1'b0;
		end else begin
			o_done     <= 1'b0;
			o_rd_valid <= 1'b0;
			if (state == C_IDLE) begin
				if (i_go) begin
					state  <= C_START;
					q      <= '0;
					tx_sh  <= {i_addr, i_rd}; // RL22
					rd     <= i_rd;
					first  <= 1'b1;
					wbuf   <= i_wdata;
					widx   <= '0;
					left   <= (i_count == 8'h00) ? 8'h01 : i_count;
					o_nack <= 1'b0;
				end
			end else if (tick) begin
				q <= q + 1'b1;
				unique case (state)
					C_START: begin
						if (q == 2'h2) begin
							sda_oe <= 1'b1;
						end else if (q == 2'h3) begin
							scl_oe <= 1'b1;
							bi     <= '0;
							state  <= C_BIT;
						end
					end
					C_BIT: begin
						unique case (q)
							2'h0: sda_oe <= drv; // RL1
							2'h1: scl_oe <= 1'b0;
							2'h2: begin
								if (rx && bi != ACK_SLOT) begin
									rx_sh <= {rx_sh[BYTE_W-2:0], bus.sda};
								end
								nacked <= bus.sda;
							end
							2'h3: begin
								scl_oe <= 1'b1;
								bi     <= bi + 1'b1;
								if (bi != ACK_SLOT) begin
									tx_sh <= {tx_sh[BYTE_W-2:0], 1'b0};
								end else begin
									bi <= '0;
									if (rx) begin
										o_rdata    <= rx_sh;
										o_rd_valid <= 1'b1;
										left       <= left - 1'b1;
										// Nack sent in this slot, then stop
										if (left == 8'h01) begin
											state <= C_STOP; // RL17
										end
									end else if (nacked) begin
										o_nack <= 1'b1;
										state  <= C_STOP;
									end else if (first || left != 8'h01) begin
										first <= 1'b0;
										if (!first) begin
											left <= left - 1'b1;
										end
										tx_sh <= wbuf[widx*BYTE_W +: BYTE_W]; // RL13
										widx  <= widx + 1'b1;
									end else begin
										state <= C_STOP;
									end
								end
							end
						endcase
					end
					C_STOP: begin
						if (q == 2'h0) begin
							sda_oe <= 1'b1; // RL5
						end else if (q == 2'h1) begin
							scl_oe <= 1'b0;
						end else if (q == 2'h2) begin
							sda_oe <= 1'b0;
						end else begin
							o_done <= 1'b1;
							state  <= C_IDLE;
						end
					end
					default: state <= C_IDLE;
				endcase
			end
		end
	end

	assign bus.ctl_scl_oe = scl_oe;
	assign bus.ctl_sda_oe = sda_oe;

endmodule

// [logic/eeprom_target.sv]
// Serial target end of a 128-byte nonvolatile memory.
// Assumes the bus lines may be asynchronous to i_clk_sys; no reset pin
// exists on the part, i_rst_n stands for power-on.
//
// How it works
// RL1: Data changes only while clock low
// RL2: Watch for start, ignore traffic before
// RL3: Start counts only after a stop
// RL4: Stop ends everything, read returns standby
// RL5: Controller stops only after line released
// RL6: Release after eight bits, receiver acks
// RL7: Acknowledge every address and direction byte
// RL8: Acknowledge every received write byte
// RL9: Keep sending while reads are acknowledged
// RL10: No ack: stop sending, await stop
// RL11: Stop after write data starts program
// RL12: Ignore bus while programming runs
// RL13: Page write holds up to four bytes
// RL14: Write bumps low two address bits only
// RL15: No ack during programming, ack after
// RL16: Programming lasts about five milliseconds
// RL17: Controller ends read by nack or stop
// RL18: Byte read returns addressed location
// RL19: Sequential read returns following addresses
// RL20: Read address wraps from top to zero
// RL21: Array of 128 eight-bit bytes
// RL22: MSB first, direction high means read
// RL23: Lines synchronised and filtered before use
// RL24: Timer ends programming with done pulse
`timescale 1ns/100ps
module eeprom_target #(
	parameter int unsigned WR_CYCLES = twe_pkg::WRITE_CYC
) (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	// Serial bus
	twe_bus_if.device bus,
	// Status
	output logic      o_busy,
	output logic      o_standby,
	output logic      o_write_done
);
	import twe_pkg::*;

	localparam int unsigned FLT_W = $clog2(FILTER_CYC + 1);
	localparam int unsigned TMR_W = $clog2(WR_CYCLES + 1);

	// ==========================================================
	// Line conditioning
	logic [1:0] meta;
	logic [1:0] stab;
	logic [1:0] filt;
	logic [1:0] filt_q;

	// Two-flop synchroniser, bit 1 clock, bit 0 data
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= 2'h3;
			stab <= 2'h3;
		end else begin
			meta <= {bus.scl, bus.sda}; // RL23
			stab <= meta;
		end
	end

	// Glitch filter: a level must hold before it is believed
	genvar g;
	for (g = 0; g < 2; g++) begin : g_filter
		logic [FLT_W-1:0] run;
		logic             level;
		always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
			if (!i_rst_n) begin
				run   <= '0;
				level <= 1'b1;
			end else if (stab[g] == level) begin
				run <= '0;
			end else if (run == FLT_W'(FILTER_CYC - 1)) begin
				run   <= '0;
				level <= stab[g]; // RL23
			end else begin
				run <= run + 1'b1;
			end
		end
		assign filt[g] = level;
	end

	// Previous filtered levels for edge detection
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			filt_q <= 2'h3;
		end else begin
			filt_q <= filt;
		end
	end

	// Bus events; data moving under a high clock is framing
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic sda_in;
	assign scl_rise = filt[1] & ~filt_q[1];
	assign scl_fall = ~filt[1] & filt_q[1];
	assign start_ev = filt[1] & filt_q[1] & filt_q[0] & ~filt[0]; // RL1
	assign stop_ev  = filt[1] & filt_q[1] & ~filt_q[0] & filt[0]; // RL1
	assign sda_in   = filt[0];

	// ==========================================================
	// Storage array and programming timer
	logic [BYTE_W-1:0] mem [MEM_DEPTH]; // RL21
	logic [TMR_W-1:0]  tmr;
	logic              busy;
	logic              wr_done;
	logic              wr_start;

	dev_state_t        state;
	logic [2:0]        cnt;
	logic [BYTE_W-1:0] sh;
	logic [ADDR_W-1:0] addr;
	logic              rw;
	logic              armed;
	logic              ack_seen;
	logic              sda_oe;
	logic [BYTE_W-1:0] page_data [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_valid;
	logic [BYTE_W-1:0] rd_byte;

	assign rd_byte  = mem[addr];
	assign wr_done  = busy && (tmr == '0); // RL24
	assign wr_start = stop_ev && !busy && (|page_valid); // RL11

	// Self-timed program cycle counted from the stop
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy <= 1'b0;
			tmr  <= '0;
		end else if (wr_start) begin
			busy <= 1'b1;
			tmr  <= TMR_W'(WR_CYCLES - 1); // RL16
		end else if (wr_done) begin
			busy <= 1'b0;
		end else if (busy) begin
			tmr <= tmr - 1'b1;
		end
	end

	// Commit the page buffer when the timer expires
	always_ff @(posedge i_clk_sys) begin
		if (wr_done) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (page_valid[i]) begin
					mem[{addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_data[i];
				end
			end
		end
	end

	// ==========================================================
	// Protocol engine
	// Page bytes are held, not programmed, until the stop; a
	// partial byte cut by the stop is dropped.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state      <= S_IDLE;
			cnt        <= '0;
			sh         <= '0;
			addr       <= '0;
			rw         <= 1'b0;
			armed      <= 1'b1;
			ack_seen   <= 1'b0;
			sda_oe     <= 1'b0;
			page_valid <= '0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				page_data[i] <= '0;
			end
		end else if (busy) begin
			// Inputs disabled; no answer to polling
			state  <= S_IDLE; // RL12
			sda_oe <= 1'b0; // RL15
			if (wr_done) begin
				page_valid <= '0;
				armed      <= 1'b1;
			end
		end else if (stop_ev) begin
			state  <= S_IDLE; // RL4
			sda_oe <= 1'b0;
			armed  <= 1'b1;
		end else if (start_ev) begin
			sda_oe <= 1'b0;
			cnt    <= '0;
			// Repeated start without stop is not a command
			state  <= armed ? S_ADDR : S_WAIT_STOP; // RL3
			armed  <= 1'b0;
		end else begin
			unique case (state)
				S_IDLE, S_WAIT_STOP: begin
					sda_oe <= 1'b0; // RL2
				end
				S_ADDR: begin
					if (scl_rise) begin
						sh  <= {sh[BYTE_W-2:0], sda_in}; // RL22
						cnt <= cnt + 1'b1;
						if (cnt == LAST_BIT) begin
							addr  <= sh[ADDR_W-1:0];
							rw    <= sda_in; // RL22
							state <= S_ADDR_ACK;
						end
					end
				end
				S_ADDR_ACK: begin
					if (scl_fall && !sda_oe) begin
						sda_oe <= 1'b1; // RL7
					end else if (scl_fall && rw == DIR_READ) begin
						sh     <= rd_byte; // RL18
						sda_oe <= ~rd_byte[BYTE_W-1];
						cnt    <= '0;
						state  <= S_RDATA;
					end else if (scl_fall) begin
						sda_oe <= 1'b0; // RL6
						state  <= S_WDATA;
					end
				end
				S_WDATA: begin
					if (scl_rise) begin
						sh  <= {sh[BYTE_W-2:0], sda_in};
						cnt <= cnt + 1'b1;
						if (cnt == LAST_BIT) begin
							page_data[addr[PAGE_W-1:0]] <=
								{sh[BYTE_W-2:0], sda_in}; // RL13
							page_valid[addr[PAGE_W-1:0]] <= 1'b1;
							// Page roll-over overwrites earlier bytes
							addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1; // RL14
							state <= S_WDATA_ACK;
						end
					end
				end
				S_WDATA_ACK: begin
					if (scl_fall && !sda_oe) begin
						sda_oe <= 1'b1; // RL8
					end else if (scl_fall) begin
						sda_oe <= 1'b0; // RL6
						state  <= S_WDATA;
					end
				end
				S_RDATA: begin
					if (scl_fall && cnt == LAST_BIT) begin
						sda_oe <= 1'b0; // RL6
						addr   <= addr + 1'b1; // RL20
						state  <= S_RACK;
					end else if (scl_fall) begin
						sh     <= {sh[BYTE_W-2:0], 1'b0};
						sda_oe <= ~sh[BYTE_W-2]; // RL1
						cnt    <= cnt + 1'b1;
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						ack_seen <= ~sda_in;
					end else if (scl_fall && ack_seen) begin
						sh     <= rd_byte; // RL19
						sda_oe <= ~rd_byte[BYTE_W-1]; // RL9
						cnt    <= '0;
						state  <= S_RDATA;
					end else if (scl_fall) begin
						state <= S_WAIT_STOP; // RL10
					end
				end
			endcase
		end
	end

	assign bus.dev_sda_oe = sda_oe;

	// ==========================================================
	// Status outputs
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_busy       <= 1'b0;
			o_standby    <= 1'b1;
			o_write_done <= 1'b0;
		end else begin
			o_busy       <= busy;
			o_standby    <= !busy && state == S_IDLE; // RL4
			o_write_done <= wr_done; // RL24
		end
	end

endmodule

// [logic/twe_bus_if.sv]
// Two-wire bus between the controller and the memory target.
// Both lines are open drain with pull-ups; levels resolve here.
`timescale 1ns/100ps
interface twe_bus_if;
	logic ctl_scl_oe;
	logic ctl_sda_oe;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND of the pulled-up lines
	assign scl = ~ctl_scl_oe;
	assign sda = ~(ctl_sda_oe | dev_sda_oe);

	modport device (input scl, input sda, output dev_sda_oe);
	modport controller (input scl, input sda,
		output ctl_scl_oe, output ctl_sda_oe);
endinterface

// [logic/twe_pkg.sv]
// Shared constants and types for the two-wire memory link.
// Assumes a single 100 MHz system clock at both ends.
package twe_pkg;

	// ==========================================================
	// Clock and bus timing
	localparam int unsigned CLK_MHZ     = 100;
	localparam int unsigned FILTER_NS   = 100;
	// Longest glitch to reject, rounded down, never below one
	localparam int unsigned FILTER_CYC  = (FILTER_NS * CLK_MHZ / 1000 > 0) ?
		FILTER_NS * CLK_MHZ / 1000 : 1;
	localparam int unsigned WRITE_MS    = 5;
	localparam int unsigned WRITE_CYC   = WRITE_MS * CLK_MHZ * 1000;
	localparam int unsigned SCL_KHZ     = 100;
	// Quarter of a serial clock period, rounded up
	localparam int unsigned QUARTER_CYC =
		(CLK_MHZ * 1000 + SCL_KHZ * 4 - 1) / (SCL_KHZ * 4);

	// ==========================================================
	// Array and frame layout
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned MEM_DEPTH  = 128;
	localparam int unsigned PAGE_W     = 2;
	localparam int unsigned PAGE_BYTES = 4;
	localparam logic [2:0]  LAST_BIT   = 3'h7;
	localparam logic [3:0]  ACK_SLOT   = 4'h8;
	localparam logic        DIR_READ   = 1'b1;

	// ==========================================================
	// State encodings
	typedef enum logic [2:0] {
		S_IDLE      = 3'b000,
		S_ADDR      = 3'b001,
		S_ADDR_ACK  = 3'b010,
		S_WDATA     = 3'b011,
		S_WDATA_ACK = 3'b100,
		S_RDATA     = 3'b101,
		S_RACK      = 3'b110,
		S_WAIT_STOP = 3'b111
	} dev_state_t;

	typedef enum logic [1:0] {
		C_IDLE  = 2'b00,
		C_START = 2'b01,
		C_BIT   = 2'b10,
		C_STOP  = 2'b11
	} ctl_state_t;

endpackage

// [tb/testbench.sv]
// Testbench joining controller and memory target over one bus.
// Assumes short program and quarter counts to keep the run brief.
`timescale 1ns/100ps
module testbench;
	// ==========================================================
	// Signals
	localparam int WR = 200;
	logic        i_clk_sys = 1'b0;
	logic        i_rst_n   = 1'b0;
	logic        i_go      = 1'b0;
	logic        i_rd      = 1'b0;
	logic [6:0]  i_addr    = 7'h00;
	logic [7:0]  i_count   = 8'h01;
	logic [31:0] i_wdata   = 32'h0;
	logic        c_busy;
	logic        c_done;
	logic        c_nack;
	logic [7:0]  c_rdata;
	logic        c_rd_valid;
	logic        t_busy;
	logic        t_standby;
	logic        t_done;
	logic [7:0]  mem [128];
	logic [7:0]  rq [$];
	int          failures   = 0;
	int          num_checks = 0;

	// 100 MHz clock
	always #5 i_clk_sys = ~i_clk_sys;

	// ==========================================================
	// Design and checker
	twe_bus_if bus ();
	bus_controller #(.QUARTER(20)) bus_controller_i (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_go(i_go), .i_rd(i_rd), .i_addr(i_addr),
		.i_count(i_count), .i_wdata(i_wdata), .o_busy(c_busy),
		.o_done(c_done), .o_nack(c_nack), .o_rdata(c_rdata),
		.o_rd_valid(c_rd_valid), .bus(bus));
	eeprom_target #(.WR_CYCLES(WR)) eeprom_target_i (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .bus(bus), .o_busy(t_busy),
		.o_standby(t_standby), .o_write_done(t_done));
	twe_assertions #(.WR_CYCLES(WR)) twe_assertions_i (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .ctl_scl_oe(bus.ctl_scl_oe),
		.ctl_sda_oe(bus.ctl_sda_oe), .dev_sda_oe(bus.dev_sda_oe),
		.scl(bus.scl), .sda(bus.sda), .o_busy(t_busy),
		.o_standby(t_standby), .o_write_done(t_done));

	// Collect read bytes as they arrive
	always @(posedge i_clk_sys) begin
		if (c_rd_valid === 1'b1)
			rq.push_back(c_rdata);
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string w, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask

	// One framed transfer; waits for done under a bound
	task automatic op(input logic r, input logic [6:0] a,
		input logic [7:0] n, input logic [31:0] d);
		int k;
		rq.delete();
		@(negedge i_clk_sys);
		i_rd = r;
		i_addr = a;
		i_count = n;
		i_wdata = d;
		i_go = 1'b1;
		@(negedge i_clk_sys);
		i_go = 1'b0;
		check("ctl busy", 8'h1, {7'h0, c_busy});
		k = 0;
		while (c_done !== 1'b1 && k < 20000) begin
			@(negedge i_clk_sys);
			k++;
		end
		check("done seen", 8'h1, {7'h0, c_done});
	endtask

	// Write, model the page rule, then poll until the target answers
	task automatic wr(input logic [6:0] a, input logic [7:0] n,
		input logic [31:0] d);
		int i;
		int p;
		for (i = 0; i < n; i++)
			mem[{a[6:2], 2'(a[1:0] + i)}] = d[8*(i%4) +: 8];
		op(1'b0, a, n, d);
		check("write nack", 8'h0, {7'h0, c_nack});
		// Poll the written byte so an unwritten cell never reaches the line
		op(1'b1, a, 8'h01, 32'h0);
		check("poll nack busy", 8'h1, {7'h0, c_nack});
		for (p = 0; p < 10 && c_nack !== 1'b0; p++)
			op(1'b1, a, 8'h01, 32'h0);
		check("poll nack done", 8'h0, {7'h0, c_nack});
		check("poll byte", mem[a], rq.size() ? rq[0] : 8'hXX);
	endtask

	// Sequential read compared with the model
	task automatic rdchk(input logic [6:0] a, input logic [7:0] n);
		int i;
		op(1'b1, a, n, 32'h0);
		check("read nack", 8'h0, {7'h0, c_nack});
		check("read count", n, 8'(rq.size()));
		for (i = 0; i < n && i < rq.size(); i++)
			check("read byte", mem[7'(a + i)], rq[i]);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_page_write();
		wr(7'h24, 8'h04, 32'h44332211);
		wr(7'h7C, 8'h04, 32'h8877665F);
		wr(7'h00, 8'h04, 32'hCCBBAA99);
		rdchk(7'h24, 8'h04);
	endtask

	// Six bytes into a four-byte page wrap and overwrite the first two written
	task automatic t_page_wrap();
		wr(7'h21, 8'h06, 32'hD4C3B2A1);
		rdchk(7'h20, 8'h08);
	endtask

	// Read across the top of the array
	task automatic t_read_wrap();
		rdchk(7'h7E, 8'h04);
		rdchk(7'h7F, 8'h01);
	endtask

	// ==========================================================
	// Verdict and sequence
	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_rst_n = 1'b1;
		t_page_write();
		t_page_wrap();
		t_read_wrap();
		end_of_test();
	end

	// Cut a hang well beyond the expected run
	initial begin
		#900000;
		failures++;
		end_of_test();
	end
endmodule

// [tb/twe_assertions.sv]
// Checker for the two-wire link between controller and memory target.
// Assumes both lines and target status are sampled on i_clk_sys.
`timescale 1ns/100ps
module twe_assertions #(
	parameter int unsigned WR_CYCLES = 200
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Bus lines
	input wire logic ctl_scl_oe,
	input wire logic ctl_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda,
	// Target status
	input wire logic o_busy,
	input wire logic o_standby,
	input wire logic o_write_done
);
	// ==========================================================
	// Frame tracking
	logic        scl_q;
	logic        sda_q;
	logic        first;
	logic        rd;
	logic        busy_st;
	logic [3:0]  bitn;
	logic [19:0] bcnt;
	wire start = scl & scl_q & sda_q & ~sda;
	wire stop  = scl & scl_q & ~sda_q & sda;
	wire rise  = scl & ~scl_q;

	// Bit slot 8 is the acknowledge clock of every byte
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			first <= 1'b0;
			rd <= 1'b0;
			busy_st <= 1'b0;
			bitn <= 4'h0;
			bcnt <= 20'h0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			bcnt <= o_busy ? bcnt + 20'h1 : 20'h0;
			if (start) begin
				bitn <= 4'h0;
				first <= 1'b1;
				busy_st <= o_busy;
			end else if (rise) begin
				bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
				if (bitn == 4'h8)
					first <= 1'b0;
				if (first && bitn == 4'h7)
					rd <= sda;
			end
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	data_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target moved data with clock high");
	rx_quiet_a: assert property (rise && bitn != 4'h8 && (first || !rd)
		|-> !dev_sda_oe) else $error("target drove a received bit");
	addr_ack_a: assert property (rise && bitn == 4'h8 && first && !busy_st
		|-> dev_sda_oe) else $error("address byte not acknowledged");
	data_ack_a: assert property (rise && bitn == 4'h8 && !first && !rd
		|-> dev_sda_oe) else $error("write byte not acknowledged");
	poll_nack_a: assert property (rise && busy_st |-> !dev_sda_oe)
		else $error("target answered while programming");
	rd_release_a: assert property (rise && bitn == 4'h8 && !first && rd
		|-> !dev_sda_oe) else $error("target held line in read ack slot");
	nack_hold_a: assert property (rise && bitn == 4'h8 && !first && rd && sda
		|-> !dev_sda_oe throughout (##[1:300] stop))
		else $error("target sent after missing acknowledge");
	stop_idle_a: assert property (stop && rd && !busy_st
		|-> ##[1:40] o_standby) else $error("no standby after read stop");
	busy_len_a: assert property ($fell(o_busy)
		|-> bcnt + 2 >= WR_CYCLES && bcnt <= WR_CYCLES + 2)
		else $error("program cycle length off");
	done_pulse_a: assert property (o_write_done
		|-> $past(o_busy, 2) ##1 !o_write_done)
		else $error("done pulse malformed");
	busy_idle_a: assert property (o_busy && $past(o_busy) |-> !o_standby)
		else $error("standby while programming");

	// Main scenarios reached
	cover property ($rose(o_busy));
	cover property (rise && bitn == 4'h8 && busy_st);
	cover property (rise && bitn == 4'h8 && !first && rd && sda);
endmodule
